// ---- rfm_register_map.sv ----
// Register file storage and address mapping for sets, banks, pages and slices
`timescale 1ns/1ps
`default_nettype none
module rfm_register_map #(
   parameter int NUM_PAGES = 10
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic acc_valid,
   input wire logic acc_write,
   input wire logic [1:0] acc_mode,
   input wire logic [7:0] acc_addr,
   input wire logic [3:0] acc_work_reg,
   input wire logic [7:0] acc_wdata,
   input wire logic bank_zero_op,
   input wire logic bank_one_op,
   input wire logic [1:0] srp_kind,
   input wire logic [7:0] srp_value,
   output logic [7:0] rdata,
   output logic rdata_valid,
   output logic bank_sel,
   output logic [7:0] working_slice_pointer_a,
   output logic [7:0] working_slice_pointer_b,
   output logic [7:0] page_select_pointer
);
   // Page numbers are four bits wide, so at most sixteen pages can be served
   if (NUM_PAGES < 1 || NUM_PAGES > 16) begin
      $error("NUM_PAGES out of range");
   end

   localparam int DATA_ENTRIES = NUM_PAGES * (rfm_pkg::PRIME_BYTES + rfm_pkg::SET2_BYTES);

   logic [7:0] prime_set2_mem [0:DATA_ENTRIES-1];
   logic [7:0] common_mem [0:15];
   logic [7:0] bank_mem [0:2*rfm_pkg::BANK_BYTES-1];
   logic [7:0] sysreg_mem [0:15];

   logic next_bank_sel;
   logic [7:0] next_ptr_a;
   logic [7:0] next_ptr_b;
   logic [7:0] next_page_ptr;
   logic [7:0] next_rdata;
   logic next_rdata_valid;

   // Effective address and target class of the current access
   logic [7:0] eff_addr;
   logic to_set1;
   logic page_ok;
   logic [3:0] page_num;
   int unsigned data_index;
   // Write strobes for the four stores
   logic wr_set1;
   logic wr_bank;
   logic wr_sysreg;
   logic wr_common;
   logic wr_data;

   // Working register address: bit 3 picks pointer, low three bits index the slice
   function automatic logic [7:0] work_addr(input logic [3:0] r, input logic [7:0] pa,
                                            input logic [7:0] pb);
      logic [7:0] base;
      base = r[3] ? pb : pa;
      return {base[7:3], r[2:0]};
   endfunction

   function automatic logic is_upper(input logic [7:0] a);
      return a >= rfm_pkg::SET1_BASE;
   endfunction

   function automatic logic in_bank_area(input logic [7:0] a);
      return a >= rfm_pkg::BANKED_BASE;
   endfunction

   function automatic logic in_sysreg_area(input logic [7:0] a);
      return a >= rfm_pkg::SYSREG_BASE && a < rfm_pkg::BANKED_BASE;
   endfunction

   always_comb begin
      eff_addr = (acc_mode == rfm_pkg::RFM_MODE_WORKING) ?
                 work_addr(acc_work_reg, working_slice_pointer_a, working_slice_pointer_b) :
                 acc_addr;
      // Direct and working modes reach set 1; indirect/indexed reach set 2
      to_set1 = is_upper(eff_addr) && (acc_mode == rfm_pkg::RFM_MODE_DIRECT ||
                acc_mode == rfm_pkg::RFM_MODE_WORKING);
      // Writes use the destination nibble, reads the source nibble
      page_num = acc_write ? page_select_pointer[7:4] : page_select_pointer[3:0];
      page_ok = (32'(page_num) < NUM_PAGES);
      data_index = 32'(page_num) * 32'(rfm_pkg::PRIME_BYTES + rfm_pkg::SET2_BYTES) +
                   32'(eff_addr);
   end

   always_comb begin
      wr_set1 = acc_valid && acc_write && to_set1;
      wr_bank = wr_set1 && in_bank_area(eff_addr);
      wr_sysreg = wr_set1 && in_sysreg_area(eff_addr);
      wr_common = wr_set1 && !in_bank_area(eff_addr) && !in_sysreg_area(eff_addr);
      wr_data = acc_valid && acc_write && !to_set1 && page_ok;
   end

   always_comb begin
      next_bank_sel = bank_sel;
      if (bank_one_op) begin
         next_bank_sel = 1'b1;
      end else if (bank_zero_op) begin
         next_bank_sel = 1'b0;
      end
      next_ptr_a = working_slice_pointer_a;
      next_ptr_b = working_slice_pointer_b;
      next_page_ptr = page_select_pointer;
      if (acc_valid && acc_write && to_set1) begin
         if (eff_addr == rfm_pkg::PTR_A_ADDR) begin
            next_ptr_a = acc_wdata;
         end
         if (eff_addr == rfm_pkg::PTR_B_ADDR) begin
            next_ptr_b = acc_wdata;
         end
         if (eff_addr == rfm_pkg::PAGE_PTR_ADDR) begin
            next_page_ptr = acc_wdata;
         end
      end
      case (srp_kind)
         rfm_pkg::RFM_SRP_BOTH: begin
            next_ptr_a = srp_value;
            next_ptr_b = srp_value + rfm_pkg::SLICE_STEP;
         end
         rfm_pkg::RFM_SRP_FIRST: begin
            next_ptr_a = srp_value;
         end
         rfm_pkg::RFM_SRP_SECOND: begin
            next_ptr_b = srp_value;
         end
         default: begin
         end
      endcase
      next_rdata_valid = acc_valid && !acc_write;
      next_rdata = 8'h00;
      if (acc_valid && !acc_write) begin
         if (to_set1) begin
            if (eff_addr == rfm_pkg::PTR_A_ADDR) begin
               next_rdata = working_slice_pointer_a;
            end else if (eff_addr == rfm_pkg::PTR_B_ADDR) begin
               next_rdata = working_slice_pointer_b;
            end else if (eff_addr == rfm_pkg::PAGE_PTR_ADDR) begin
               next_rdata = page_select_pointer;
            end else if (in_bank_area(eff_addr)) begin
               next_rdata = bank_mem[{bank_sel, eff_addr[4:0]}];
            end else if (in_sysreg_area(eff_addr)) begin
               next_rdata = sysreg_mem[eff_addr[3:0]];
            end else begin
               next_rdata = common_mem[eff_addr[3:0]];
            end
         end else if (page_ok) begin
            next_rdata = prime_set2_mem[data_index];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         bank_sel <= 1'b0;
         working_slice_pointer_a <= rfm_pkg::PTR_A_RESET;
         working_slice_pointer_b <= rfm_pkg::PTR_B_RESET;
         page_select_pointer <= rfm_pkg::PAGE_PTR_RESET;
         rdata <= 8'h00;
         rdata_valid <= 1'b0;
      end else begin
         bank_sel <= next_bank_sel;
         working_slice_pointer_a <= next_ptr_a;
         working_slice_pointer_b <= next_ptr_b;
         page_select_pointer <= next_page_ptr;
         rdata <= next_rdata;
         rdata_valid <= next_rdata_valid;
      end
   end

   // Storage writes; no reset on data arrays
   always_ff @(posedge ref_clk) begin
      if (wr_bank) begin
         bank_mem[{bank_sel, eff_addr[4:0]}] <= acc_wdata;
      end
      if (wr_sysreg) begin
         sysreg_mem[eff_addr[3:0]] <= acc_wdata;
      end
      if (wr_common) begin
         common_mem[eff_addr[3:0]] <= acc_wdata;
      end
      if (wr_data) begin
         prime_set2_mem[data_index] <= acc_wdata;
      end
   end

   // Pointer set ops, bank ops and reset values
   a_srp_both_pair: assert property (@(posedge ref_clk) disable iff (!rstn)
      srp_kind == rfm_pkg::RFM_SRP_BOTH |=> working_slice_pointer_b ==
         $past(srp_value) + rfm_pkg::SLICE_STEP && working_slice_pointer_a == $past(srp_value))
      else $error("combined pointer set wrong");
   a_srp_first_only: assert property (@(posedge ref_clk) disable iff (!rstn)
      srp_kind == rfm_pkg::RFM_SRP_FIRST && !(acc_valid && acc_write) |=>
         $stable(working_slice_pointer_b) && working_slice_pointer_a == $past(srp_value))
      else $error("first pointer op disturbed second");
   a_srp_second_only: assert property (@(posedge ref_clk) disable iff (!rstn)
      srp_kind == rfm_pkg::RFM_SRP_SECOND && !(acc_valid && acc_write) |=>
         $stable(working_slice_pointer_a) && working_slice_pointer_b == $past(srp_value))
      else $error("second pointer op disturbed first");
   a_bank_one_sel: assert property (@(posedge ref_clk) disable iff (!rstn)
      bank_one_op |=> bank_sel) else $error("bank one not selected");
   a_bank_zero_sel: assert property (@(posedge ref_clk) disable iff (!rstn)
      bank_zero_op && !bank_one_op |=> !bank_sel) else $error("bank zero not selected");
   a_reset_values: assert property (@(posedge ref_clk)
      !rstn |=> working_slice_pointer_a == rfm_pkg::PTR_A_RESET &&
         working_slice_pointer_b == rfm_pkg::PTR_B_RESET && !bank_sel &&
         page_select_pointer == rfm_pkg::PAGE_PTR_RESET) else $error("bad reset values");
   // Working operands in the upper area land in set 1: a read of the first pointer's own address returns it
   a_work_never_set2: assert property (@(posedge ref_clk) disable iff (!rstn)
      acc_valid && !acc_write && acc_mode == rfm_pkg::RFM_MODE_WORKING &&
      work_addr(acc_work_reg, working_slice_pointer_a, working_slice_pointer_b) ==
      rfm_pkg::PTR_A_ADDR |=> rdata == $past(working_slice_pointer_a))
      else $error("working access reached set 2");
   a_work_ptr_write: assert property (@(posedge ref_clk) disable iff (!rstn)
      acc_valid && acc_write && acc_mode == rfm_pkg::RFM_MODE_WORKING &&
      work_addr(acc_work_reg, working_slice_pointer_a, working_slice_pointer_b) ==
      rfm_pkg::PTR_B_ADDR && srp_kind == rfm_pkg::RFM_SRP_NONE |=>
         working_slice_pointer_b == $past(acc_wdata)) else $error("working pointer write lost");
   a_work_slice_base: assert property (@(posedge ref_clk) disable iff (!rstn)
      acc_mode == rfm_pkg::RFM_MODE_WORKING |-> eff_addr[7:3] ==
         (acc_work_reg[3] ? working_slice_pointer_b[7:3] : working_slice_pointer_a[7:3]))
      else $error("working address base wrong");
   a_ptr_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      acc_valid && acc_write && acc_mode == rfm_pkg::RFM_MODE_DIRECT &&
      acc_addr == rfm_pkg::PTR_A_ADDR && srp_kind == rfm_pkg::RFM_SRP_NONE |=>
         working_slice_pointer_a == $past(acc_wdata)) else $error("pointer A write lost");

   // Read answers: valid in the cycle after each read, zero data between reads
   a_read_latency: assert property (@(posedge ref_clk) disable iff (!rstn)
      acc_valid && !acc_write |=> rdata_valid)
      else $error("read valid not one cycle");
   a_read_idle_low: assert property (@(posedge ref_clk) disable iff (!rstn)
      !(acc_valid && !acc_write) |=> !rdata_valid && rdata == 8'h00)
      else $error("read valid without a read");
   a_read_ptr_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      acc_valid && !acc_write && acc_mode == rfm_pkg::RFM_MODE_DIRECT &&
      acc_addr == rfm_pkg::PTR_A_ADDR |=> rdata == $past(working_slice_pointer_a))
      else $error("pointer A read wrong");
   a_read_ptr_b: assert property (@(posedge ref_clk) disable iff (!rstn)
      acc_valid && !acc_write && acc_mode == rfm_pkg::RFM_MODE_DIRECT &&
      acc_addr == rfm_pkg::PTR_B_ADDR |=> rdata == $past(working_slice_pointer_b))
      else $error("pointer B read wrong");
   a_read_page_ptr: assert property (@(posedge ref_clk) disable iff (!rstn)
      acc_valid && !acc_write && acc_mode == rfm_pkg::RFM_MODE_DIRECT &&
      acc_addr == rfm_pkg::PAGE_PTR_ADDR |=> rdata == $past(page_select_pointer))
      else $error("page pointer read wrong");
   a_page_refused: assert property (@(posedge ref_clk) disable iff (!rstn)
      acc_valid && !acc_write && acc_mode != rfm_pkg::RFM_MODE_WORKING &&
      acc_addr < rfm_pkg::SET1_BASE && 32'(page_select_pointer[3:0]) >= NUM_PAGES |=>
         rdata == 8'h00) else $error("read of unbacked page not zero");

   // Register loads
   a_ptr_write_b: assert property (@(posedge ref_clk) disable iff (!rstn)
      acc_valid && acc_write && acc_mode == rfm_pkg::RFM_MODE_DIRECT &&
      acc_addr == rfm_pkg::PTR_B_ADDR && srp_kind == rfm_pkg::RFM_SRP_NONE |=>
         working_slice_pointer_b == $past(acc_wdata)) else $error("pointer B write lost");
   a_page_ptr_write: assert property (@(posedge ref_clk) disable iff (!rstn)
      acc_valid && acc_write && acc_mode == rfm_pkg::RFM_MODE_DIRECT &&
      acc_addr == rfm_pkg::PAGE_PTR_ADDR |=>
         page_select_pointer == $past(acc_wdata)) else $error("page pointer write lost");

   // Registers hold between their own loads
   a_ptr_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
      srp_kind == rfm_pkg::RFM_SRP_NONE && !(acc_valid && acc_write) |=>
         $stable(working_slice_pointer_a) && $stable(working_slice_pointer_b))
      else $error("slice pointer changed without a load");
   a_page_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
      !(acc_valid && acc_write) |=> $stable(page_select_pointer))
      else $error("page pointer changed without a load");
   a_set2_no_ptr: assert property (@(posedge ref_clk) disable iff (!rstn)
      acc_valid && acc_write && (acc_mode == rfm_pkg::RFM_MODE_INDIRECT ||
      acc_mode == rfm_pkg::RFM_MODE_INDEXED) && srp_kind == rfm_pkg::RFM_SRP_NONE |=>
         $stable(working_slice_pointer_a) && $stable(working_slice_pointer_b) &&
         $stable(page_select_pointer)) else $error("set 2 write reached a pointer");
   a_bank_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
      !bank_zero_op && !bank_one_op |=> $stable(bank_sel))
      else $error("bank changed without a bank op");
endmodule
`default_nettype wire

// ---- rfm_pkg.sv ----
// Constants for the register file address map
package rfm_pkg;
   localparam logic [7:0] SET1_BASE = 8'hc0;
   localparam logic [7:0] BANKED_BASE = 8'he0;
   localparam logic [7:0] SYSREG_BASE = 8'hd0;
   localparam logic [7:0] PTR_A_ADDR = 8'hd6;
   localparam logic [7:0] PTR_B_ADDR = 8'hd7;
   localparam logic [7:0] PAGE_PTR_ADDR = 8'hdf;
   localparam logic [7:0] PTR_A_RESET = 8'hc0;
   localparam logic [7:0] PTR_B_RESET = 8'hc8;
   localparam logic [7:0] PAGE_PTR_RESET = 8'h00;
   localparam logic [7:0] SLICE_STEP = 8'h08;
   localparam logic [3:0] HIGH_PAGE = 4'hf;
   localparam int SET2_BYTES = 64;
   localparam int BANK_BYTES = 32;
   localparam int PRIME_BYTES = 192;
   // Addressing modes as seen on the core register bus
   typedef enum logic [1:0] {
      RFM_MODE_DIRECT = 2'b00,
      RFM_MODE_WORKING = 2'b01,
      RFM_MODE_INDIRECT = 2'b10,
      RFM_MODE_INDEXED = 2'b11
   } rfm_mode_e;
   // Set pointer instruction kinds
   typedef enum logic [1:0] {
      RFM_SRP_NONE = 2'b00,
      RFM_SRP_BOTH = 2'b01,
      RFM_SRP_FIRST = 2'b10,
      RFM_SRP_SECOND = 2'b11
   } rfm_srp_e;
endpackage

// ---- rfm_core_model.sv ----
// Core-side model that drives register accesses and pointer ops
`timescale 1ns/1ps
`default_nettype none
module rfm_core_model (
   input wire logic ref_clk,
   output logic acc_valid,
   output logic acc_write,
   output logic [1:0] acc_mode,
   output logic [7:0] acc_addr,
   output logic [3:0] acc_work_reg,
   output logic [7:0] acc_wdata,
   output logic bank_zero_op,
   output logic bank_one_op,
   output logic [1:0] srp_kind,
   output logic [7:0] srp_value
);
   initial begin
      {acc_valid, acc_write, acc_mode, bank_zero_op, bank_one_op, srp_kind} = '0;
      {acc_addr, acc_work_reg, acc_wdata, srp_value} = '0;
   end
   // Held across one rising edge; released fields show inverted values
   task automatic access(input logic w, input logic [1:0] m, input logic [7:0] a,
      input logic [3:0] r, input logic [7:0] d);
      @(negedge ref_clk);
      {acc_valid, acc_write, acc_mode, acc_addr, acc_work_reg, acc_wdata} = {1'b1, w, m, a, r, d};
      @(negedge ref_clk);
      acc_valid = 1'b0;
      {acc_addr, acc_work_reg, acc_wdata} = ~{a, r, d};
   endtask
   task automatic op(input logic b0, input logic b1, input logic [1:0] k, input logic [7:0] v);
      @(negedge ref_clk);
      {bank_zero_op, bank_one_op, srp_kind, srp_value} = {b0, b1, k, v};
      @(negedge ref_clk);
      {bank_zero_op, bank_one_op, srp_kind} = '0;
      srp_value = ~v;
   endtask
endmodule
`default_nettype wire

// ---- rfm_register_map_tb_top.sv ----
// Testbench for the register file address map
`timescale 1ns/1ps
`default_nettype none
module rfm_register_map_tb_top;
   localparam logic [1:0] DIR = rfm_pkg::RFM_MODE_DIRECT;
   localparam logic [1:0] WRK = rfm_pkg::RFM_MODE_WORKING;
   localparam logic [1:0] IND = rfm_pkg::RFM_MODE_INDIRECT;
   localparam logic [1:0] IDX = rfm_pkg::RFM_MODE_INDEXED;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic acc_valid, acc_write, bank_zero_op, bank_one_op, rdata_valid, bank_sel;
   logic [1:0] acc_mode, srp_kind;
   logic [3:0] acc_work_reg;
   logic [7:0] acc_addr, acc_wdata, srp_value, rdata, pa, pb, pp;
   logic [1:0] pm [3] = '{DIR, IND, IDX};
   int num_errors = 0;
   int n_compared = 0;
   int cycles = 0;
   always #20 ref_clk = ~ref_clk;
   rfm_core_model core (.ref_clk, .acc_valid, .acc_write, .acc_mode, .acc_addr,
      .acc_work_reg, .acc_wdata, .bank_zero_op, .bank_one_op, .srp_kind, .srp_value);
   rfm_register_map #(.NUM_PAGES(10)) DUT (.ref_clk, .rstn, .acc_valid, .acc_write,
      .acc_mode, .acc_addr, .acc_work_reg, .acc_wdata, .bank_zero_op, .bank_one_op,
      .srp_kind, .srp_value, .rdata, .rdata_valid, .bank_sel,
      .working_slice_pointer_a(pa), .working_slice_pointer_b(pb), .page_select_pointer(pp));
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic final_report();
      if (num_errors == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic wr(input logic [1:0] m, input logic [7:0] a, input logic [3:0] r,
      input logic [7:0] d);
      core.access(1'b1, m, a, r, d);
   endtask
   task automatic rd(input logic [1:0] m, input logic [7:0] a, input logic [3:0] r,
      input logic [7:0] e);
      core.access(1'b0, m, a, r, 8'h00);
      chk("rdata_valid", 8'h01, {7'h00, rdata_valid});
      chk("rdata", e, rdata);
   endtask
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 2000) begin
         num_errors++;
         final_report();
      end
   end
   initial begin
      repeat (6) @(negedge ref_clk);
      rstn = 1'b1;
      chk("ptr_a", 8'hc0, pa);
      chk("ptr_b", 8'hc8, pb);
      chk("page", 8'h00, pp);
      chk("bank", 8'h00, {7'h00, bank_sel});
      rd(DIR, 8'hd6, 4'h0, 8'hc0);
      rd(DIR, 8'hd7, 4'h0, 8'hc8);
      wr(DIR, 8'hc9, 4'h0, 8'h5a);
      wr(IND, 8'hc9, 4'h0, 8'ha5);
      rd(WRK, 8'h00, 4'h9, 8'h5a);
      rd(DIR, 8'hc9, 4'h0, 8'h5a);
      rd(IDX, 8'hc9, 4'h0, 8'ha5);
      wr(IND, 8'hd6, 4'h0, 8'h99);
      rd(DIR, 8'hd6, 4'h0, 8'hc0);
      rd(IND, 8'hd6, 4'h0, 8'h99);
      foreach (pm[i]) begin
         wr(pm[i], 8'(8'h40 + i), 4'h0, 8'(8'h30 + i));
         rd(pm[(i + 1) % 3], 8'(8'h40 + i), 4'h0, 8'(8'h30 + i));
      end
      wr(DIR, 8'he5, 4'h0, 8'h11);
      wr(DIR, 8'hd0, 4'h0, 8'h66);
      core.op(1'b0, 1'b1, 2'b00, 8'h00);
      chk("bank", 8'h01, {7'h00, bank_sel});
      wr(DIR, 8'he5, 4'h0, 8'h22);
      rd(DIR, 8'hd0, 4'h0, 8'h66);
      rd(DIR, 8'he5, 4'h0, 8'h22);
      core.op(1'b1, 1'b0, 2'b00, 8'h00);
      rd(DIR, 8'he5, 4'h0, 8'h11);
      wr(DIR, 8'hdf, 4'h0, 8'h11);
      chk("page", 8'h11, pp);
      wr(DIR, 8'h40, 4'h0, 8'h44);
      wr(IND, 8'hc9, 4'h0, 8'h77);
      rd(DIR, 8'hc9, 4'h0, 8'h5a);
      wr(DIR, 8'hdf, 4'h0, 8'h10);
      rd(DIR, 8'hdf, 4'h0, 8'h10);
      rd(DIR, 8'h40, 4'h0, 8'h30);
      rd(IND, 8'hc9, 4'h0, 8'ha5);
      wr(DIR, 8'hdf, 4'h0, 8'h01);
      rd(IDX, 8'h40, 4'h0, 8'h44);
      rd(IND, 8'hc9, 4'h0, 8'h77);
      wr(DIR, 8'hdf, 4'h0, 8'hff);
      rd(DIR, 8'h40, 4'h0, 8'h00);
      wr(DIR, 8'hdf, 4'h0, 8'h00);
      core.op(1'b0, 1'b0, rfm_pkg::RFM_SRP_BOTH, 8'h70);
      chk("ptr_a", 8'h70, pa);
      chk("ptr_b", 8'h78, pb);
      core.op(1'b0, 1'b0, rfm_pkg::RFM_SRP_SECOND, 8'h48);
      chk("ptr_a", 8'h70, pa);
      chk("ptr_b", 8'h48, pb);
      core.op(1'b0, 1'b0, rfm_pkg::RFM_SRP_FIRST, 8'h40);
      chk("ptr_a", 8'h40, pa);
      chk("ptr_b", 8'h48, pb);
      rd(WRK, 8'h00, 4'h1, 8'h31);
      wr(DIR, 8'hd7, 4'h0, 8'hc0);
      wr(DIR, 8'hd6, 4'h0, 8'hc8);
      rd(WRK, 8'h00, 4'h1, 8'h5a);
      wr(WRK, 8'h00, 4'h9, 8'h3c);
      rd(DIR, 8'hc1, 4'h0, 8'h3c);
      wr(DIR, 8'hd6, 4'h0, 8'hd0);
      rd(WRK, 8'h00, 4'h6, 8'hd0);
      wr(WRK, 8'h00, 4'h7, 8'hb8);
      chk("ptr_b", 8'hb8, pb);
      wr(DIR, 8'hdf, 4'h0, 8'h33);
      core.op(1'b1 ^ 1'b1, 1'b1, rfm_pkg::RFM_SRP_NONE, 8'h00);
      chk("bank", 8'h01, {7'h00, bank_sel});
      rstn = 1'b0;
      repeat (2) @(negedge ref_clk);
      rstn = 1'b1;
      chk("bank", 8'h00, {7'h00, bank_sel});
      chk("ptr_a", 8'hc0, pa);
      chk("ptr_b", 8'hc8, pb);
      chk("page", 8'h00, pp);
      rd(DIR, 8'h40, 4'h0, 8'h30);
      final_report();
   end
endmodule
`default_nettype wire
